// file: pad_io_port_with_waveform.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module pad_io_port_with_waveform
	import pad_port_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [11:0] pad_in_i,
	output logic [11:0] pad_out_o,
	output logic [11:0] pad_oe_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [31:0] addr, input logic [29:0] idx);
		return addr[31:2] == idx;
	endfunction : hit

	function automatic logic mapped(input logic [31:0] addr);
		return (addr[31:2] >= IDX_PAD_LEVEL_UPPER) && (addr[31:2] <= IDX_WAVE_CONTROL);
	endfunction : mapped

	// ----------------------------------------------------------------
	// bus write channel state
	// ----------------------------------------------------------------
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [31:0] wr_addr_reg, wr_addr_next;
	logic [31:0] wr_data_reg, wr_data_next;
	logic wr_lane_reg, wr_lane_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic wr_fire;
	logic [7:0] wd;

	assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign wd = wr_data_reg[7:0];

	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		wr_lane_next = wr_lane_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid_i && !aw_held_reg) begin
			aw_held_next = 1'b1;
			wr_addr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !w_held_reg) begin
			w_held_next = 1'b1;
			wr_data_next = s_axi_wdata_i;
			wr_lane_next = s_axi_wstrb_i[0];
		end
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = mapped(wr_addr_reg) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			wr_addr_reg <= 32'h00000000;
			wr_data_reg <= 32'h00000000;
			wr_lane_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
			wr_lane_reg <= wr_lane_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	assign s_axi_awready_o = ~aw_held_reg;
	assign s_axi_wready_o = ~w_held_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_bresp_o = bresp_reg;

	// only the low byte lane carries register data
	function automatic logic wr_to(input logic [29:0] idx);
		return wr_fire && wr_lane_reg && hit(wr_addr_reg, idx);
	endfunction : wr_to

	// ----------------------------------------------------------------
	// pad input synchroniser
	// ----------------------------------------------------------------
	logic [11:0] sync_reg [SYNC_STAGES];
	logic [11:0] live_reg, live_next;

	always_comb begin
		live_next = live_reg;
		for (int b = 0; b < PAD_COUNT; b++) begin
			if (sync_reg[1][b] == sync_reg[2][b]) begin
				live_next[b] = sync_reg[2][b];
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int s = 0; s < SYNC_STAGES; s++) begin
				sync_reg[s] <= 12'h000;
			end
			live_reg <= 12'h000;
		end else begin
			sync_reg[0] <= pad_in_i;
			for (int s = 1; s < SYNC_STAGES; s++) begin
				sync_reg[s] <= sync_reg[s - 1];
			end
			live_reg <= live_next;
		end
	end

	// ----------------------------------------------------------------
	// output values and directions
	// ----------------------------------------------------------------
	logic [11:0] out_reg, out_next;
	logic [11:0] dir_reg, dir_next;

	always_comb begin
		out_next = out_reg;
		dir_next = dir_reg;
		if (wr_to(IDX_PAD_LEVEL_UPPER)) out_next[11:8] = wd[3:0];
		if (wr_to(IDX_PAD_LEVEL_LOWER)) out_next[7:0] = wd;
		if (wr_to(IDX_OUTPUT_FLIP_UPPER)) out_next[11:8] = out_reg[11:8] ^ wd[3:0];
		if (wr_to(IDX_OUTPUT_FLIP_LOWER)) out_next[7:0] = out_reg[7:0] ^ wd;
		if (wr_to(IDX_OUTPUT_HIGH_UPPER)) out_next[11:8] = out_reg[11:8] | wd[3:0];
		if (wr_to(IDX_OUTPUT_HIGH_LOWER)) out_next[7:0] = out_reg[7:0] | wd;
		if (wr_to(IDX_OUTPUT_LOW_UPPER)) out_next[11:8] = out_reg[11:8] & ~wd[3:0];
		if (wr_to(IDX_OUTPUT_LOW_LOWER)) out_next[7:0] = out_reg[7:0] & ~wd;
		if (wr_to(IDX_PAD_DIRECTION_UPPER)) dir_next[11:8] = wd[3:0];
		if (wr_to(IDX_PAD_DIRECTION_LOWER)) dir_next[7:0] = wd;
		if (wr_to(IDX_DIRECTION_FLIP_UPPER)) dir_next[11:8] = dir_reg[11:8] ^ wd[3:0];
		if (wr_to(IDX_DIRECTION_FLIP_LOWER)) dir_next[7:0] = dir_reg[7:0] ^ wd;
		if (wr_to(IDX_MAKE_INPUT_UPPER)) dir_next[11:8] = dir_reg[11:8] | wd[3:0];
		if (wr_to(IDX_MAKE_INPUT_LOWER)) dir_next[7:0] = dir_reg[7:0] | wd;
		if (wr_to(IDX_MAKE_OUTPUT_UPPER)) dir_next[11:8] = dir_reg[11:8] & ~wd[3:0];
		if (wr_to(IDX_MAKE_OUTPUT_LOWER)) dir_next[7:0] = dir_reg[7:0] & ~wd;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_reg <= OUT_RESET;
			dir_reg <= {DIR_UPPER_RESET, DIR_LOWER_RESET};
		end else begin
			out_reg <= out_next;
			dir_reg <= dir_next;
		end
	end

	// ----------------------------------------------------------------
	// waveform configuration
	// ----------------------------------------------------------------
	logic [7:0] span_reg [SPAN_COUNT][2];
	logic [7:0] span_next [SPAN_COUNT][2];
	logic [2:0] ctl_reg, ctl_next;
	logic wide;

	assign wide = ctl_reg[CTL_WIDE_BIT];

	always_comb begin
		span_next = span_reg;
		ctl_next = ctl_reg;
		for (int k = 0; k < SPAN_COUNT; k++) begin
			if (wr_to(IDX_WAVE_SPAN_BASE + 30'(2 * k))) span_next[k][1] = wd;
			if (wr_to(IDX_WAVE_SPAN_BASE + 30'(2 * k + 1))) span_next[k][0] = wd;
		end
		if (wr_to(IDX_WAVE_CONTROL)) ctl_next = wd[2:0];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int k = 0; k < SPAN_COUNT; k++) begin
				span_reg[k][0] <= SPAN_RESET;
				span_reg[k][1] <= SPAN_RESET;
			end
			ctl_reg <= CTL_RESET;
		end else begin
			span_reg <= span_next;
			ctl_reg <= ctl_next;
		end
	end

	// length of the current span of channel c
	function automatic logic [15:0] span_len(input int c, input span_e sp);
		logic [2:0] k;
		k = sp;
		if (c == 0 && wide) begin
			return {span_reg[k][1], span_reg[k][0]};
		end
		return {8'h00, span_reg[k][c]};
	endfunction : span_len

	// ----------------------------------------------------------------
	// waveform generators
	// ----------------------------------------------------------------
	wave_chan_s wave_reg [2];
	wave_chan_s wave_next [2];
	logic [7:0] rem_reg [2];
	logic [7:0] rem_next [2];
	logic [1:0] fin_reg, fin_next;

	always_comb begin
		logic chan_en;
		logic finite;
		logic [15:0] len;
		logic [15:0] left;
		chan_en = 1'b0;
		finite = 1'b0;
		len = 16'h0000;
		left = 16'h0000;
		wave_next = wave_reg;
		rem_next = rem_reg;
		fin_next = fin_reg;
		for (int c = 0; c < 2; c++) begin
			chan_en = ctl_reg[c] & ~(c == 1 && wide);
			if (!chan_en) begin
				wave_next[c] = WAVE_CHAN_RESET;
			end else if (!wave_reg[c].run && !wave_reg[c].done) begin
				wave_next[c].run = 1'b1;
				wave_next[c].span = SPAN_ONE;
				wave_next[c].cnt = 16'h0000;
				wave_next[c].level = 1'b1;
			end else if (wave_reg[c].run) begin
				len = span_len(c, wave_reg[c].span);
				if ({1'b0, wave_reg[c].cnt} + 17'h00001 >= {1'b0, len}) begin
					wave_next[c].cnt = 16'h0000;
					wave_next[c].level = ~wave_reg[c].level;
					case (wave_reg[c].span)
						SPAN_ONE: wave_next[c].span = SPAN_TWO;
						SPAN_TWO: wave_next[c].span = SPAN_THREE;
						SPAN_THREE: wave_next[c].span = SPAN_FOUR;
						SPAN_FOUR: wave_next[c].span = SPAN_FIVE;
						default: begin
							wave_next[c].span = SPAN_ONE;
							wave_next[c].level = 1'b1;
							finite = (c == 0 && wide) ? |fin_reg : fin_reg[c];
							left = (c == 0 && wide) ? {rem_reg[1], rem_reg[0]} :
								{8'h00, rem_reg[c]};
							if (finite) begin
								left = left - 16'h0001;
								if (c == 0 && wide) begin
									rem_next[1] = left[15:8];
									rem_next[0] = left[7:0];
								end else begin
									rem_next[c] = left[7:0];
								end
								if (left == 16'h0000) begin
									wave_next[c].run = 1'b0;
									wave_next[c].done = 1'b1;
									wave_next[c].level = 1'b0;
								end
							end
						end
					endcase
				end else begin
					wave_next[c].cnt = wave_reg[c].cnt + 16'h0001;
				end
			end
		end
		if (wr_to(IDX_WAVE_PERIOD_COUNT_HIGH)) begin
			rem_next[1] = wd;
			fin_next[1] = |wd;
		end
		if (wr_to(IDX_WAVE_PERIOD_COUNT_LOW)) begin
			rem_next[0] = wd;
			fin_next[0] = |wd;
		end
		if (wr_to(IDX_WAVE_PERIOD_COUNT_HIGH) || wr_to(IDX_WAVE_PERIOD_COUNT_LOW)) begin
			wave_next[0].done = 1'b0;
			wave_next[1].done = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int c = 0; c < 2; c++) begin
				wave_reg[c] <= WAVE_CHAN_RESET;
				rem_reg[c] <= COUNT_RESET;
			end
			fin_reg <= 2'h0;
		end else begin
			wave_reg <= wave_next;
			rem_reg <= rem_next;
			fin_reg <= fin_next;
		end
	end

	// ----------------------------------------------------------------
	// pad drive
	// ----------------------------------------------------------------
	logic [11:0] drive_reg, drive_next;

	always_comb begin
		drive_next = out_reg;
		for (int c = 0; c < 2; c++) begin
			if (wave_reg[c].run) drive_next[c] = wave_reg[c].level;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			drive_reg <= OUT_RESET;
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign pad_out_o = drive_reg;
	assign pad_oe_o = ~dir_reg;

	// ----------------------------------------------------------------
	// bus read channel
	// ----------------------------------------------------------------
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid_i && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next = 32'h00000000;
			rresp_next = mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
			if (hit(s_axi_araddr_i, IDX_PAD_LEVEL_UPPER)) rdata_next[3:0] = live_reg[11:8];
			if (hit(s_axi_araddr_i, IDX_PAD_LEVEL_LOWER)) rdata_next[7:0] = live_reg[7:0];
			if (hit(s_axi_araddr_i, IDX_PAD_DIRECTION_UPPER)) rdata_next[3:0] = dir_reg[11:8];
			if (hit(s_axi_araddr_i, IDX_PAD_DIRECTION_LOWER)) rdata_next[7:0] = dir_reg[7:0];
			for (int k = 0; k < SPAN_COUNT; k++) begin
				if (hit(s_axi_araddr_i, IDX_WAVE_SPAN_BASE + 30'(2 * k))) begin
					rdata_next[7:0] = span_reg[k][1];
				end
				if (hit(s_axi_araddr_i, IDX_WAVE_SPAN_BASE + 30'(2 * k + 1))) begin
					rdata_next[7:0] = span_reg[k][0];
				end
			end
			if (hit(s_axi_araddr_i, IDX_WAVE_PERIOD_COUNT_HIGH)) rdata_next[7:0] = rem_reg[1];
			if (hit(s_axi_araddr_i, IDX_WAVE_PERIOD_COUNT_LOW)) rdata_next[7:0] = rem_reg[0];
			if (hit(s_axi_araddr_i, IDX_WAVE_CONTROL)) rdata_next[2:0] = ctl_reg;
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_arready_o = ~rvalid_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;

endmodule : pad_io_port_with_waveform
`default_nettype wire

// file: pad_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pad_partner (
	input wire logic [11:0] pad_out_i,
	input wire logic [11:0] pad_oe_i,
	input wire logic [11:0] ext_level_i,
	output logic [11:0] pad_in_o
);
	// driven pads show the port value, others the outside level
	assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule : pad_partner
`default_nettype wire

// file: pad_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pad_port_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [11:0] pad_out_o,
	input wire logic [11:0] pad_oe_o
);
	// ----
	// bus steps
	// ----
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence write_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o;
	endsequence
	sequence b_waiting;
		s_axi_bvalid_o && !s_axi_bready_i;
	endsequence
	sequence r_waiting;
		s_axi_rvalid_o && !s_axi_rready_i;
	endsequence
	// ----
	// checks
	// ----
	chk_reset_all_inputs: assert property ($past(rst_i) |-> pad_oe_o == 12'h000)
		else $error("pad driven right after reset");
	chk_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid_o)
		else $error("write response missing");
	chk_write_held: assert property (write_taken |=> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write ready not dropped");
	chk_b_hold: assert property (b_waiting |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response not held");
	chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data late");
	chk_r_hold: assert property (r_waiting |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data not held");
	chk_read_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address taken while busy");
	chk_dir_cause: assert property ($changed(pad_oe_o) |-> $rose(s_axi_bvalid_o))
		else $error("pad direction changed without write");
	chk_out_cause: assert property ($changed(pad_out_o[11:2])
		|-> $past(s_axi_bvalid_o) && !$past(s_axi_bvalid_o, 2))
		else $error("pad value changed without write");
	chk_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response not released");
	chk_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data not released");
endmodule : pad_port_monitor
bind pad_io_port_with_waveform pad_port_monitor u_pad_port_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o));
`default_nettype wire

// file: pad_port_pkg.sv
package pad_port_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [29:0] IDX_PAD_LEVEL_UPPER = 30'h00001070;
	localparam logic [29:0] IDX_PAD_LEVEL_LOWER = 30'h00001071;
	localparam logic [29:0] IDX_OUTPUT_FLIP_UPPER = 30'h00001072;
	localparam logic [29:0] IDX_OUTPUT_FLIP_LOWER = 30'h00001073;
	localparam logic [29:0] IDX_OUTPUT_HIGH_UPPER = 30'h00001074;
	localparam logic [29:0] IDX_OUTPUT_HIGH_LOWER = 30'h00001075;
	localparam logic [29:0] IDX_OUTPUT_LOW_UPPER = 30'h00001076;
	localparam logic [29:0] IDX_OUTPUT_LOW_LOWER = 30'h00001077;
	localparam logic [29:0] IDX_PAD_DIRECTION_UPPER = 30'h00001078;
	localparam logic [29:0] IDX_PAD_DIRECTION_LOWER = 30'h00001079;
	localparam logic [29:0] IDX_DIRECTION_FLIP_UPPER = 30'h0000107a;
	localparam logic [29:0] IDX_DIRECTION_FLIP_LOWER = 30'h0000107b;
	localparam logic [29:0] IDX_MAKE_INPUT_UPPER = 30'h0000107c;
	localparam logic [29:0] IDX_MAKE_INPUT_LOWER = 30'h0000107d;
	localparam logic [29:0] IDX_MAKE_OUTPUT_UPPER = 30'h0000107e;
	localparam logic [29:0] IDX_MAKE_OUTPUT_LOWER = 30'h0000107f;
	// span pairs: base + 2k is the pad-1 half, base + 2k + 1 the pad-0 half
	localparam logic [29:0] IDX_WAVE_SPAN_BASE = 30'h00001080;
	localparam logic [29:0] IDX_WAVE_PERIOD_COUNT_HIGH = 30'h0000108a;
	localparam logic [29:0] IDX_WAVE_PERIOD_COUNT_LOW = 30'h0000108b;
	localparam logic [29:0] IDX_WAVE_CONTROL = 30'h0000108c;

	// ----------------------------------------------------------------
	// sizes, fields and reset values
	// ----------------------------------------------------------------
	localparam int PAD_COUNT = 12;
	localparam int SPAN_COUNT = 5;
	localparam int SYNC_STAGES = 3;
	localparam int CTL_EN0_BIT = 0;
	localparam int CTL_EN1_BIT = 1;
	localparam int CTL_WIDE_BIT = 2;
	localparam logic [3:0] DIR_UPPER_RESET = 4'hf;
	localparam logic [7:0] DIR_LOWER_RESET = 8'hff;
	localparam logic [11:0] OUT_RESET = 12'h000;
	localparam logic [7:0] SPAN_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// waveform channel state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SPAN_ONE,
		SPAN_TWO,
		SPAN_THREE,
		SPAN_FOUR,
		SPAN_FIVE
	} span_e;

	typedef struct packed {
		logic run;
		logic done;
		logic level;
		span_e span;
		logic [15:0] cnt;
	} wave_chan_s;

	localparam wave_chan_s WAVE_CHAN_RESET = '{
		run: 1'b0, done: 1'b0, level: 1'b0, span: SPAN_ONE, cnt: 16'h0000};

endpackage : pad_port_pkg

// file: tb_pad_io_port_with_waveform.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pad_io_port_with_waveform import pad_port_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [11:0] pad_in, pad_out, pad_oe;
	logic [11:0] ext_level = 12'ha5c;
	int fail_count = 0;
	int tests_run = 0;
	logic [29:0] t_idx [12] = '{IDX_OUTPUT_HIGH_LOWER, IDX_OUTPUT_LOW_LOWER,
		IDX_OUTPUT_FLIP_LOWER, IDX_OUTPUT_HIGH_UPPER, IDX_OUTPUT_LOW_UPPER,
		IDX_OUTPUT_FLIP_UPPER, IDX_DIRECTION_FLIP_LOWER, IDX_MAKE_INPUT_UPPER,
		IDX_MAKE_OUTPUT_UPPER, IDX_MAKE_INPUT_LOWER, IDX_MAKE_OUTPUT_LOWER,
		IDX_DIRECTION_FLIP_UPPER};
	logic [7:0] t_dat [12] = '{8'h01, 8'h80, 8'hff, 8'h02, 8'h04, 8'h09, 8'h11, 8'h08,
		8'h01, 8'h01, 8'h10, 8'h0f};
	logic [11:0] t_out [12] = '{12'h597, 12'h517, 12'h5e8, 12'h7e8, 12'h3e8, 12'hae8,
		12'hae8, 12'hae8, 12'hae8, 12'hae8, 12'hae8, 12'hae8};
	logic [11:0] t_oe [12] = '{12'hcf0, 12'hcf0, 12'hcf0, 12'hcf0, 12'hcf0, 12'hcf0,
		12'hce1, 12'h4e1, 12'h5e1, 12'h5e0, 12'h5f0, 12'haf0};
	pad_io_port_with_waveform u_pad_io_port_with_waveform (.clk_i(clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pad_in_i(pad_in),
		.pad_out_o(pad_out), .pad_oe_o(pad_oe));
	pad_partner u_pad_partner (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
		.ext_level_i(ext_level), .pad_in_o(pad_in));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ----
	// tasks
	// ----
	task finish_test;
		$display("mismatches %0d, comparisons %0d", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task check_data(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check_data
	task check_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : check_resp
	task chk_done(input logic ok);
		if (!ok) begin
			fail_count++;
			$display("Error handshake timed out");
			finish_test();
		end
	endtask : chk_done
	task wr(input logic [29:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		logic done;
		@(posedge clk_i);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done && n < 40) begin
			@(posedge clk_i);
			n++;
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				bready <= 1'b0;
				check_resp($sformatf("bresp %h", idx), er, bresp);
			end
		end
		chk_done(done);
	endtask : wr
	task rd(input logic [29:0] idx, input logic [7:0] e, input logic [1:0] er);
		int n;
		logic done;
		@(posedge clk_i);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done && n < 40) begin
			@(posedge clk_i);
			n++;
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1'b1;
				rready <= 1'b0;
				check_data($sformatf("rdata %h", idx), {24'h0, e}, rdata);
				check_resp($sformatf("rresp %h", idx), er, rresp);
			end
		end
		chk_done(done);
	endtask : rd
	task pads(input logic [11:0] eo, input logic [11:0] ee);
		@(posedge clk_i);
		check_data("pad_out", {20'h0, eo}, {20'h0, pad_out});
		check_data("pad_oe", {20'h0, ee}, {20'h0, pad_oe});
	endtask : pads
	// ----
	// sequence
	// ----
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IDX_PAD_DIRECTION_LOWER, 8'hff, RESP_OKAY);
		rd(IDX_PAD_DIRECTION_UPPER, 8'h0f, RESP_OKAY);
		rd(IDX_OUTPUT_FLIP_LOWER, 8'h00, RESP_OKAY);
		rd(IDX_WAVE_SPAN_BASE, 8'h00, RESP_OKAY);
		rd(IDX_WAVE_SPAN_BASE + 30'h1, 8'h00, RESP_OKAY);
		pads(12'h000, 12'h000);
		rd(IDX_PAD_LEVEL_LOWER, 8'h5c, RESP_OKAY);
		rd(IDX_PAD_LEVEL_UPPER, 8'h0a, RESP_OKAY);
		wr(IDX_PAD_LEVEL_LOWER, 8'h96, RESP_OKAY);
		wr(IDX_PAD_LEVEL_UPPER, 8'h05, RESP_OKAY);
		pads(12'h596, 12'h000);
		rd(IDX_PAD_LEVEL_LOWER, 8'h5c, RESP_OKAY);
		wr(IDX_PAD_DIRECTION_LOWER, 8'h0f, RESP_OKAY);
		wr(IDX_PAD_DIRECTION_UPPER, 8'h03, RESP_OKAY);
		pads(12'h596, 12'hcf0);
		repeat (6) @(posedge clk_i);
		rd(IDX_PAD_LEVEL_LOWER, 8'h9c, RESP_OKAY);
		rd(IDX_PAD_LEVEL_UPPER, 8'h06, RESP_OKAY);
		for (int i = 0; i < 12; i++) begin
			wr(t_idx[i], t_dat[i], RESP_OKAY);
			pads(t_out[i], t_oe[i]);
		end
		rd(IDX_PAD_DIRECTION_LOWER, 8'h0f, RESP_OKAY);
		wr(IDX_WAVE_SPAN_BASE, 8'ha5, RESP_OKAY);
		wr(IDX_WAVE_SPAN_BASE + 30'h1, 8'h5a, RESP_OKAY);
		rd(IDX_WAVE_SPAN_BASE, 8'ha5, RESP_OKAY);
		rd(IDX_WAVE_SPAN_BASE + 30'h1, 8'h5a, RESP_OKAY);
		wr(30'h00002000, 8'hff, RESP_SLVERR);
		rd(30'h00002000, 8'h00, RESP_SLVERR);
		pads(12'hae8, 12'haf0);
		// lower eight pads driven low before the waveform tests
		wr(IDX_OUTPUT_LOW_LOWER, 8'hff, RESP_OKAY);
		wr(IDX_MAKE_OUTPUT_LOWER, 8'hff, RESP_OKAY);
		pads(12'ha00, 12'haff);
		wr(IDX_WAVE_SPAN_BASE, 8'h01, RESP_OKAY);
		wr(IDX_WAVE_SPAN_BASE + 30'h1, 8'h02, RESP_OKAY);
		wr(IDX_WAVE_PERIOD_COUNT_LOW, 8'h03, RESP_OKAY);
		wr(IDX_WAVE_CONTROL, 8'h01, RESP_OKAY);
		@(posedge clk_i);
		pads(12'ha01, 12'haff);
		rd(IDX_WAVE_PERIOD_COUNT_LOW, 8'h03, RESP_OKAY);
		repeat (30) @(posedge clk_i);
		rd(IDX_WAVE_PERIOD_COUNT_LOW, 8'h00, RESP_OKAY);
		pads(12'ha00, 12'haff);
		wr(IDX_WAVE_CONTROL, 8'h04, RESP_OKAY);
		wr(IDX_WAVE_PERIOD_COUNT_LOW, 8'h01, RESP_OKAY);
		wr(IDX_WAVE_CONTROL, 8'h05, RESP_OKAY);
		repeat (100) @(posedge clk_i);
		pads(12'ha01, 12'haff);
		rd(IDX_WAVE_PERIOD_COUNT_LOW, 8'h01, RESP_OKAY);
		repeat (200) @(posedge clk_i);
		rd(IDX_WAVE_PERIOD_COUNT_LOW, 8'h00, RESP_OKAY);
		wr(IDX_WAVE_SPAN_BASE + 30'h9, 8'h3c, RESP_OKAY);
		rd(IDX_WAVE_SPAN_BASE + 30'h9, 8'h3c, RESP_OKAY);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		pads(12'h000, 12'h000);
		rd(IDX_PAD_DIRECTION_LOWER, 8'hff, RESP_OKAY);
		finish_test();
	end
endmodule : tb_pad_io_port_with_waveform
`default_nettype wire
